// [logic/admc_pkg.sv]
// package for the analog die mode controller: offsets, fields, timing
package admc_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] ADMC_SYSCTL_OFS = 8'h00; // system control
    localparam logic [7:0] ADMC_IMASK_OFS = 8'h04; // interrupt mask
    localparam logic [7:0] ADMC_IFLAG_OFS = 8'h08; // interrupt flags
    localparam logic [7:0] ADMC_RSTSRC_OFS = 8'h0C; // reset source register
    localparam logic [7:0] ADMC_STATUS_OFS = 8'h10; // mode and pin status
    localparam logic [7:0] ADMC_WDCTL_OFS = 8'h14; // watchdog service
    // system control fields
    localparam int ADMC_PWRON_BIT = 0; // power_stage_on_bit
    localparam int ADMC_STOP_BIT = 1; // stop request
    localparam int ADMC_SLEEP_BIT = 2; // sleep request
    localparam int ADMC_STAGE_LSB = 8; // per-stage enables
    localparam int ADMC_STAGES = 8; // number of stage enables
    // interrupt mask and flag fields
    localparam int ADMC_WAKE_PIN_BIT = 0; // wake_pin_int_enable / flag
    localparam int ADMC_BUS_WAKE_BIT = 1; // bus_wake_int_enable / flag
    // reset source fields
    localparam int ADMC_RS_POR_BIT = 0; // power-on / sleep wake
    localparam int ADMC_RS_WD_BIT = 1; // watchdog
    localparam int ADMC_RS_EXT_BIT = 2; // external reset
    localparam int ADMC_RS_WPIN_BIT = 3; // wake_pin_reset_flag
    localparam int ADMC_RS_BUS_BIT = 4; // bus_wake_reset_flag
    // watchdog service key
    localparam logic [7:0] ADMC_WD_KEY = 8'hA5; // correct service value
    // reset values
    localparam logic [31:0] ADMC_SYSCTL_RST = 32'h0000_0000;
    localparam logic [31:0] ADMC_ZERO = 32'h0000_0000;
    // timing at 20 mhz
    localparam int ADMC_CLK_NS = 50; // clock period
    localparam int ADMC_CONFIRM_MS = 80; // startup_confirm_timeout
    localparam int ADMC_CONFIRM_CYC = ADMC_CONFIRM_MS * 1000000 / ADMC_CLK_NS;
    localparam int ADMC_DOM_US = 30; // bus_dominant_min_time
    localparam int ADMC_DOM_CYC = (ADMC_DOM_US * 1000 + ADMC_CLK_NS - 1) / ADMC_CLK_NS;
    localparam int ADMC_WD_MS = 100; // watchdog timeout
    localparam int ADMC_WD_CYC = ADMC_WD_MS * 1000000 / ADMC_CLK_NS;
    localparam int ADMC_RST_HOLD = 16; // reset pulse cycles
    // operating modes
    typedef enum logic [2:0] {
        ADMC_RESET = 3'b000,
        ADMC_NORMREQ = 3'b001,
        ADMC_NORMAL = 3'b010,
        ADMC_STOP = 3'b011,
        ADMC_SLEEP = 3'b100
    } admc_mode_e;
    // registered power outputs
    typedef struct packed {
        logic regulator_on; // vdd regulator enable
        logic reg_low_power; // reduced current capability
        logic lin_rx_en; // lin receiver enable
    } admc_power_s;
endpackage : admc_pkg

// [logic/admc_sync.sv]
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module admc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // first stage, read only by q
    // two stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : admc_sync

// [logic/admc_top.sv]
// operating-mode and supervision controller of the analog companion die
// Operation
// RULE1: confirm power stages within 80 ms else sleep
// RULE2: test pin disables timeout and lin receiver
// RULE3: watchdog resets on timeout or wrong service
// RULE4: watchdog reset clears registers except reset source
// RULE5: stop and sleep bits choose three modes
// RULE6: normal mode: stages individually enabled by software
// RULE7: stop entered only when stop bit set
// RULE8: stop keeps regulator on at reduced current
// RULE9: stop wakes on bus or pin, masked
// RULE10: enabled stop wake raises interrupt output
// RULE11: wake source flags readable in interrupt flags
// RULE12: sleep turns regulator off, reset held low
// RULE13: sleep wake unmaskable, acts as power-on reset
// RULE14: bus wake needs rising edge after long dominant
// RULE15: every reset clears all interrupt enables
// RULE16: timeout counter restarts each reset, stops on confirm
// RULE17: stop plus sleep together means sleep
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module admc_top
    import admc_pkg::*;
#(
    parameter int CONFIRM_CYC = ADMC_CONFIRM_CYC, // startup timeout cycles
    parameter int WD_CYC = ADMC_WD_CYC // watchdog timeout cycles
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins from outside
    input wire logic test_select_pin,
    input wire logic wake_input_pin,
    input wire logic lin_rx_dominant,
    input wire logic ext_reset_n,
    // outputs toward the mcu and analog blocks
    output logic reset_out_n,
    output logic irq_out,
    output admc_power_s power_o,
    output logic [ADMC_STAGES-1:0] stage_en_o,
    output logic [2:0] mode_o
);
    // synchronised pins
    logic [3:0] pins_s;
    logic test_s; // test select level
    logic wpin_s; // wake input level
    logic dom_s; // lin dominant level
    logic extn_s; // external reset level, low active
    admc_sync #(.W(4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({test_select_pin, wake_input_pin, lin_rx_dominant, ext_reset_n}),
        .q(pins_s)
    );
    assign {test_s, wpin_s, dom_s, extn_s} = pins_s;

    // state
    admc_mode_e mode_r, mode_nxt; // current mode
    logic [31:0] sysctl_r; // system control
    logic [1:0] imask_r; // interrupt enables
    logic [1:0] iflag_r; // wake flags
    logic [4:0] rstsrc_r; // reset source
    logic [31:0] confirm_cnt_r; // startup timeout counter
    logic [31:0] wd_cnt_r; // watchdog counter
    logic [7:0] rst_cnt_r; // reset pulse counter
    logic [15:0] dom_cnt_r; // dominant length counter
    logic dom_long_r; // dominant longer than minimum
    logic dom_d_r; // previous dominant level
    logic wpin_d_r; // previous wake pin level
    logic extn_d_r; // previous external reset level
    logic soft_rst; // watchdog or external reset event
    logic wd_fire; // watchdog reset event
    logic sleep_wake; // sleep wake event
    logic bus_wake_ev; // qualified lin wake edge
    logic pin_wake_ev; // wake pin change
    logic timeout; // startup timeout expired

    // axi handshake state
    logic aw_hold_r, w_hold_r; // captured halves
    logic [7:0] aw_addr_r; // captured address
    logic [31:0] w_data_r; // captured data
    logic [3:0] w_strb_r; // captured strobes
    logic wr_go; // both halves present
    logic sysctl_wr, imask_wr, iflag_wr, wd_wr; // write decodes
    logic [31:0] wmask; // byte mask from strobes

    // write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // write decode
    always_comb begin
        sysctl_wr = 1'b0;
        imask_wr = 1'b0;
        iflag_wr = 1'b0;
        wd_wr = 1'b0;
        if (wr_go && aw_addr_r == ADMC_SYSCTL_OFS) begin
            sysctl_wr = 1'b1;
        end else if (wr_go && aw_addr_r == ADMC_IMASK_OFS) begin
            imask_wr = 1'b1;
        end else if (wr_go && aw_addr_r == ADMC_IFLAG_OFS) begin
            iflag_wr = 1'b1;
        end else if (wr_go && aw_addr_r == ADMC_WDCTL_OFS) begin
            wd_wr = 1'b1;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == ADMC_SYSCTL_OFS) begin
                s_axi_rdata <= sysctl_r;
            end else if (s_axi_araddr == ADMC_IMASK_OFS) begin
                s_axi_rdata <= {30'h0, imask_r};
            end else if (s_axi_araddr == ADMC_IFLAG_OFS) begin
                s_axi_rdata <= {30'h0, iflag_r}; // RULE11
            end else if (s_axi_araddr == ADMC_RSTSRC_OFS) begin
                s_axi_rdata <= {27'h0, rstsrc_r};
            end else if (s_axi_araddr == ADMC_STATUS_OFS) begin
                s_axi_rdata <= {28'h0, test_s, mode_r};
            end else begin
                s_axi_rdata <= 32'h0000_0000; // unmapped reads zero
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    // watchdog: timeout or bad key
    assign wd_fire = (mode_r == ADMC_NORMAL)
        && ((wd_cnt_r >= 32'(WD_CYC - 1)) || (wd_wr && w_data_r[7:0] != ADMC_WD_KEY)); // RULE3
    assign soft_rst = wd_fire || (extn_d_r && !extn_s);

    // lin wake qualification
    always_ff @(posedge aclk) begin
        if (!aresetn || !test_s == 1'b0) begin
            dom_cnt_r <= 16'h0000; // RULE2
            dom_long_r <= 1'b0;
            dom_d_r <= 1'b0;
        end else begin
            dom_d_r <= dom_s;
            if (dom_s) begin
                if (dom_cnt_r < 16'(ADMC_DOM_CYC)) begin
                    dom_cnt_r <= dom_cnt_r + 16'h0001;
                end
                dom_long_r <= (dom_cnt_r >= 16'(ADMC_DOM_CYC - 1)); // RULE14
            end else begin
                dom_cnt_r <= 16'h0000;
                dom_long_r <= 1'b0;
            end
        end
    end
    assign bus_wake_ev = dom_d_r && !dom_s && dom_long_r && !test_s; // RULE14
    assign pin_wake_ev = wpin_d_r != wpin_s;
    assign sleep_wake = (mode_r == ADMC_SLEEP) && (bus_wake_ev || pin_wake_ev); // RULE13

    // edge history registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wpin_d_r <= 1'b0;
            extn_d_r <= 1'b0; // no false edge
        end else begin
            wpin_d_r <= wpin_s;
            extn_d_r <= extn_s;
        end
    end

    // control registers, cleared by any reset but reset source
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || sleep_wake) begin
            sysctl_r <= ADMC_SYSCTL_RST; // RULE4
            imask_r <= 2'b00; // RULE15
        end else begin
            if (sysctl_wr) begin
                sysctl_r <= (sysctl_r & ~wmask) | (w_data_r & wmask); // RULE6
            end
            if (mode_r != ADMC_NORMAL && mode_r != ADMC_NORMREQ) begin
                sysctl_r[ADMC_STOP_BIT] <= 1'b0; // mode requests consumed
                sysctl_r[ADMC_SLEEP_BIT] <= 1'b0;
            end
            if (imask_wr && w_strb_r[0]) begin
                imask_r <= w_data_r[1:0];
            end
        end
    end

    // wake flags: set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || sleep_wake) begin
            iflag_r <= 2'b00; // RULE4
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (iflag_wr && w_strb_r[0] && w_data_r[i]) begin
                    iflag_r[i] <= 1'b0;
                end
            end
            if (mode_r == ADMC_STOP && pin_wake_ev && imask_r[ADMC_WAKE_PIN_BIT]) begin
                iflag_r[ADMC_WAKE_PIN_BIT] <= 1'b1; // RULE11
            end
            if (mode_r == ADMC_STOP && bus_wake_ev && imask_r[ADMC_BUS_WAKE_BIT]) begin
                iflag_r[ADMC_BUS_WAKE_BIT] <= 1'b1; // RULE11
            end
        end
    end

    // reset source register survives watchdog reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rstsrc_r <= 5'b00001;
        end else if (sleep_wake) begin
            rstsrc_r <= {bus_wake_ev, pin_wake_ev, 3'b001}; // RULE13
        end else if (wd_fire) begin
            rstsrc_r[ADMC_RS_WD_BIT] <= 1'b1; // RULE4
        end else if (soft_rst) begin
            rstsrc_r <= 5'b00100;
        end
    end

    // startup timeout counter
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || sleep_wake || mode_r == ADMC_RESET) begin
            confirm_cnt_r <= 32'h0000_0000; // RULE16
        end else if (mode_r == ADMC_NORMREQ && !test_s) begin
            confirm_cnt_r <= confirm_cnt_r + 32'h0000_0001; // RULE1
        end
    end
    assign timeout = (mode_r == ADMC_NORMREQ) && !test_s
        && (confirm_cnt_r >= 32'(CONFIRM_CYC - 1)); // RULE1 RULE2

    // watchdog counter runs only in normal mode
    always_ff @(posedge aclk) begin
        if (!aresetn || mode_r != ADMC_NORMAL || wd_wr || wd_fire) begin
            wd_cnt_r <= 32'h0000_0000;
        end else begin
            wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
        end
    end

    // reset pulse length
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || sleep_wake || mode_r != ADMC_RESET) begin
            rst_cnt_r <= 8'h00;
        end else begin
            rst_cnt_r <= rst_cnt_r + 8'h01;
        end
    end

    // mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ADMC_RESET: begin
                if (rst_cnt_r >= 8'(ADMC_RST_HOLD - 1)) begin
                    mode_nxt = ADMC_NORMREQ;
                end
            end
            ADMC_NORMREQ: begin
                if (timeout) begin
                    mode_nxt = ADMC_SLEEP; // RULE1
                end else if (sysctl_r[ADMC_PWRON_BIT]) begin
                    mode_nxt = ADMC_NORMAL; // RULE16
                end
            end
            ADMC_NORMAL: begin
                if (sysctl_r[ADMC_SLEEP_BIT]) begin
                    mode_nxt = ADMC_SLEEP; // RULE12 RULE17
                end else if (sysctl_r[ADMC_STOP_BIT]) begin
                    mode_nxt = ADMC_STOP; // RULE5 RULE7
                end
            end
            ADMC_STOP: begin
                if ((pin_wake_ev && imask_r[ADMC_WAKE_PIN_BIT])
                    || (bus_wake_ev && imask_r[ADMC_BUS_WAKE_BIT])) begin
                    mode_nxt = ADMC_NORMAL; // RULE9
                end
            end
            ADMC_SLEEP: begin
                mode_nxt = ADMC_SLEEP;
            end
            default: begin
                mode_nxt = ADMC_RESET;
            end
        endcase
    end

    // mode register
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || sleep_wake) begin
            mode_r <= ADMC_RESET; // RULE13
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_out_n <= 1'b0;
            irq_out <= 1'b0;
            power_o <= '0;
            stage_en_o <= '0;
            mode_o <= 3'b000;
        end else begin
            reset_out_n <= (mode_nxt == ADMC_NORMREQ || mode_nxt == ADMC_NORMAL
                || mode_nxt == ADMC_STOP) && !soft_rst && !sleep_wake; // RULE12
            irq_out <= (mode_r == ADMC_STOP) && (mode_nxt == ADMC_NORMAL); // RULE10
            power_o.regulator_on <= (mode_nxt != ADMC_SLEEP) || sleep_wake; // RULE8 RULE12
            power_o.reg_low_power <= (mode_nxt == ADMC_STOP); // RULE8
            power_o.lin_rx_en <= !test_s && (mode_nxt == ADMC_NORMAL); // RULE2
            stage_en_o <= (mode_nxt == ADMC_NORMAL && sysctl_r[ADMC_PWRON_BIT])
                ? sysctl_r[ADMC_STAGE_LSB +: ADMC_STAGES] : '0; // RULE6
            mode_o <= mode_nxt;
        end
    end

    // assertions
    sequence s_stop_wake;
        (mode_r == ADMC_STOP) && (pin_wake_ev && imask_r[ADMC_WAKE_PIN_BIT]);
    endsequence
    property p_timeout_sleep;
        @(posedge aclk) disable iff (!aresetn)
        (timeout && !soft_rst && !sleep_wake) |=> (mode_r == ADMC_SLEEP);
    endproperty
    a_timeout_sleep: assert property (p_timeout_sleep) else $error("no sleep on timeout"); // RULE1
    property p_test_no_lin;
        @(posedge aclk) disable iff (!aresetn)
        test_s |=> !power_o.lin_rx_en;
    endproperty
    a_test_no_lin: assert property (p_test_no_lin) else $error("lin rx on in test"); // RULE2
    property p_wd_reset;
        @(posedge aclk) disable iff (!aresetn)
        wd_fire |=> (mode_r == ADMC_RESET) && !reset_out_n && rstsrc_r[ADMC_RS_WD_BIT];
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing"); // RULE3
    property p_wd_clear;
        @(posedge aclk) disable iff (!aresetn)
        wd_fire |=> (sysctl_r == ADMC_ZERO) && (imask_r == 2'b00);
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("registers kept after wd"); // RULE4 RULE15
    property p_stop_wake_irq;
        @(posedge aclk) disable iff (!aresetn)
        s_stop_wake |=> irq_out && (mode_r == ADMC_NORMAL) ##0 iflag_r[ADMC_WAKE_PIN_BIT];
    endproperty
    a_stop_wake_irq: assert property (p_stop_wake_irq) else $error("stop wake lost"); // RULE9 RULE10
    property p_stop_regulator;
        @(posedge aclk) disable iff (!aresetn)
        (mode_r == ADMC_STOP) ##1 (mode_r == ADMC_STOP) |-> power_o.regulator_on;
    endproperty
    a_stop_regulator: assert property (p_stop_regulator) else $error("stop regulator off"); // RULE8
    property p_sleep_off;
        @(posedge aclk) disable iff (!aresetn)
        (mode_r == ADMC_SLEEP) ##1 (mode_r == ADMC_SLEEP) |-> !power_o.regulator_on && !reset_out_n;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep supply on"); // RULE12
    property p_both_sleep;
        @(posedge aclk) disable iff (!aresetn)
        (mode_r == ADMC_NORMAL && sysctl_r[ADMC_SLEEP_BIT] && !soft_rst) |=> (mode_r == ADMC_SLEEP);
    endproperty
    a_both_sleep: assert property (p_both_sleep) else $error("sleep not preferred"); // RULE17
endmodule : admc_top

// [verification/admc_far.sv]
// far-side pin model: bus line, wake input and external reset
`timescale 1ns/1ps
module admc_far (
    // clock
    input wire logic aclk,
    // pins toward the controller
    output logic lin_rx_dominant,
    output logic wake_input_pin,
    output logic ext_reset_n
);
    // recessive bus, quiet wake pin, no external reset
    initial begin
        lin_rx_dominant = 1'b0;
        wake_input_pin = 1'b0;
        ext_reset_n = 1'b1;
    end
    // dominant for n cycles, then the rising edge back to recessive
    task automatic bus_pulse(input int n);
        @(posedge aclk);
        lin_rx_dominant <= 1'b1;
        repeat (n) @(posedge aclk);
        lin_rx_dominant <= 1'b0;
    endtask : bus_pulse
    // one state change of the wake input
    task automatic pin_flip();
        @(posedge aclk);
        wake_input_pin <= ~wake_input_pin;
    endtask : pin_flip
    // external reset pulse
    task automatic ext_pulse();
        @(posedge aclk);
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge aclk);
        ext_reset_n <= 1'b1;
    endtask : ext_pulse
endmodule : admc_far

// [verification/testbench.sv]
// self-checking bench for the mode controller over axi4-lite
`timescale 1ns/1ps
module testbench
    import admc_pkg::*;
;
    // clock, reset and bus drive
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic test_pin = 1'b0;
    logic [3:0] wstrb = 4'hF;
    // design outputs and pins
    logic awready, wready, bvalid, arready, rvalid, irq, rst_n, lin_dom, wake_pin, ext_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    admc_power_s pwr;
    logic [7:0] stages;
    logic [2:0] mode;
    int errors = 0;
    int checked = 0;
    int irqs = 0, n0;
    // short counts keep the run brief
    admc_top #(.CONFIRM_CYC(200), .WD_CYC(500)) i_admc_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .test_select_pin(test_pin), .wake_input_pin(wake_pin), .lin_rx_dominant(lin_dom),
        .ext_reset_n(ext_n), .reset_out_n(rst_n), .irq_out(irq), .power_o(pwr),
        .stage_en_o(stages), .mode_o(mode));
    admc_far i_admc_far (.aclk(aclk), .lin_rx_dominant(lin_dom),
        .wake_input_pin(wake_pin), .ext_reset_n(ext_n));
    // 50 ns clock
    always #25 aclk = ~aclk;
    // count one-cycle interrupt pulses
    always @(posedge aclk) if (irq === 1'b1) irqs <= irqs + 1;
    // compare and report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write, each half released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        bit aw = 1'b1;
        bit w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((aw || w) && n < 200) begin
            @(posedge aclk);
            n++;
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 400);
        bready <= 1'b0;
        chk("write resp", 32'h0, 32'(bresp));
        chk("write done", 32'h1, 32'(n < 400));
    endtask : wr
    // one read, result left in rd
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 200);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 400);
        rd = rdata;
        rready <= 1'b0;
        chk("read resp", 32'h0, 32'(rresp));
        chk("read done", 32'h1, 32'(n < 400));
    endtask : rdr
    // bounded wait for a mode
    task automatic wait_mode(input logic [2:0] m);
        int n = 0;
        while (mode !== m && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk("mode", 32'(m), 32'(mode));
    endtask : wait_mode
    // reset held for 8 cycles
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset
    // reset, then confirm to reach normal
    task automatic boot(input logic [31:0] ctl);
        do_reset();
        wait_mode(ADMC_NORMREQ);
        wr(ADMC_SYSCTL_OFS, ctl);
        wait_mode(ADMC_NORMAL);
    endtask : boot
    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // hang guard
    initial begin
        repeat (60000) @(posedge aclk);
        errors++;
        end_sim();
    end
    // test sequence
    initial begin
        do_reset();
        rdr(ADMC_IMASK_OFS);
        chk("imask", 32'h0, rd);
        wait_mode(ADMC_NORMREQ);
        repeat (150) @(posedge aclk);
        chk("mode", 32'(ADMC_NORMREQ), 32'(mode));
        wait_mode(ADMC_SLEEP);
        chk("regulator", 32'h0, 32'(pwr.regulator_on));
        chk("reset out", 32'h0, 32'(rst_n));
        i_admc_far.pin_flip();
        wait_mode(ADMC_NORMREQ);
        rdr(ADMC_RSTSRC_OFS);
        chk("pin wake src", 32'h1, 32'(rd[ADMC_RS_WPIN_BIT]));
        $display("test timeout and sleep wake done");
        wr(ADMC_SYSCTL_OFS, 32'h0000_5A01);
        wait_mode(ADMC_NORMAL);
        chk("stages", 32'h5A, 32'(stages));
        wstrb <= 4'h1;
        wr(ADMC_SYSCTL_OFS, 32'hFF01);
        rdr(ADMC_SYSCTL_OFS);
        chk("strobe", 32'h5A01, rd);
        repeat (300) @(posedge aclk);
        chk("mode", 32'(ADMC_NORMAL), 32'(mode));
        wr(ADMC_WDCTL_OFS, 32'(ADMC_WD_KEY));
        repeat (300) @(posedge aclk);
        chk("mode", 32'(ADMC_NORMAL), 32'(mode));
        wr(ADMC_IMASK_OFS, 32'h3);
        wr(ADMC_WDCTL_OFS, 32'h3C);
        wait_mode(ADMC_NORMREQ);
        rdr(ADMC_SYSCTL_OFS);
        chk("sysctl", 32'h0, rd);
        rdr(ADMC_IMASK_OFS);
        chk("imask", 32'h0, rd);
        rdr(ADMC_RSTSRC_OFS);
        chk("kept src", 32'h1, 32'(rd[ADMC_RS_WPIN_BIT]));
        chk("wd src", 32'h1, 32'(rd[ADMC_RS_WD_BIT]));
        $display("test normal and watchdog key done");
        for (int i = 0; i < 2; i++) begin
            boot(32'h1);
            wr(ADMC_IMASK_OFS, 32'h1 << i);
            wr(ADMC_SYSCTL_OFS, 32'h3);
            wait_mode(ADMC_STOP);
            chk("stop reg", 32'h3, {30'h0, pwr.regulator_on, pwr.reg_low_power});
            n0 = irqs;
            if (i == 0) i_admc_far.bus_pulse(700);
            else i_admc_far.bus_pulse(100);
            repeat (10) @(posedge aclk);
            chk("no irq", 32'(n0), 32'(irqs));
            if (i == 0) i_admc_far.pin_flip();
            else i_admc_far.bus_pulse(700);
            repeat (10) @(posedge aclk);
            chk("irq", 32'(n0 + 1), 32'(irqs));
            rdr(ADMC_IFLAG_OFS);
            chk("iflag", 32'h1 << i, rd & 32'h3);
        end
        $display("test stop wake done");
        for (int i = 0; i < 2; i++) begin
            boot(32'h1);
            wr(ADMC_SYSCTL_OFS, i == 0 ? 32'h5 : 32'h7);
            wait_mode(ADMC_SLEEP);
            i_admc_far.bus_pulse(700);
            wait_mode(ADMC_NORMREQ);
            rdr(ADMC_RSTSRC_OFS);
            chk("bus wake src", 32'h1, 32'(rd[ADMC_RS_BUS_BIT]));
        end
        boot(32'h1);
        wait_mode(ADMC_NORMREQ);
        rdr(ADMC_RSTSRC_OFS);
        chk("wd src", 32'h1, 32'(rd[ADMC_RS_WD_BIT]));
        $display("test sleep request and watchdog timeout done");
        test_pin <= 1'b1;
        do_reset();
        wait_mode(ADMC_NORMREQ);
        repeat (400) @(posedge aclk);
        chk("mode", 32'(ADMC_NORMREQ), 32'(mode));
        chk("lin rx", 32'h0, 32'(pwr.lin_rx_en));
        rdr(8'h40);
        chk("unmapped", 32'h0, rd);
        i_admc_far.ext_pulse();
        rdr(ADMC_RSTSRC_OFS);
        chk("ext src", 32'h1, 32'(rd[ADMC_RS_EXT_BIT]));
        $display("test mode pin done");
        end_sim();
    end
endmodule : testbench
